// ---- logic/rtcs_consts.vh ----
// named constants for the rtc control and status block
// assumes inclusion by every rtcs design file
`ifndef RTCS_CONSTS_VH
`define RTCS_CONSTS_VH

// ---------------------------------------------------------------
// serial link
// ---------------------------------------------------------------
`define RTCS_SLAVE_ADDR 7'h6F

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define RTCS_ADDR_TIME_FIRST 8'h00
`define RTCS_ADDR_TIME_LAST 8'h06
`define RTCS_ADDR_STATUS 8'h07
`define RTCS_ADDR_INTCTL 8'h08
`define RTCS_ADDR_TS_FIRST 8'h14
`define RTCS_ADDR_TS_LAST 8'h19
`define RTCS_TIME_BYTES 7
`define RTCS_TS_BYTES 6

// ---------------------------------------------------------------
// status_flags fields
// ---------------------------------------------------------------
`define RTCS_SR_PLOSS 0
`define RTCS_SR_BAT 1
`define RTCS_SR_ALM 2
`define RTCS_SR_EVT 3
`define RTCS_SR_WREN 4
`define RTCS_SR_OSCDIS 6
`define RTCS_SR_AUTOCLR 7

// ---------------------------------------------------------------
// interrupt_output_control fields
// ---------------------------------------------------------------
`define RTCS_INT_SEL_MSB 3
`define RTCS_INT_SEL_LSB 0
`define RTCS_INT_FOBAT 4
`define RTCS_INT_SWMODE 5
`define RTCS_INT_ALARM_FUNCTION_ENABLE 6
`define RTCS_INT_PULSE 7

// ---------------------------------------------------------------
// reset values and output select codes
// ---------------------------------------------------------------
`define RTCS_RST_BYTE 8'h00
`define RTCS_RST_PLOSS 1'b1
`define RTCS_SEL_OFF 4'h0
`define RTCS_SEL_TB 4'h1

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RTCS_CLK_HZ 200000000
`define RTCS_TB_HZ 32768
`define RTCS_TB_HALF_CYC (`RTCS_CLK_HZ / (2 * `RTCS_TB_HZ))
`define RTCS_PULSE_MS 250
`define RTCS_PULSE_CYC ((`RTCS_CLK_HZ / 1000) * `RTCS_PULSE_MS)
`define RTCS_SEC_MASK 15'h7FFF

`endif

// ---- logic/rtcs_i2c_slave.v ----
// two-wire serial slave: address match, pointer, byte strobes
// assumes scl/sda already synchronised to clock by the parent
`timescale 1ns/10ps
`include "rtcs_consts.vh"

module rtcs_i2c_slave (
  input wire clock,
  input wire rst_b,
  input wire enable,
  input wire scl_s,
  input wire sda_s,
  input wire [7:0] rd_data,
  output wire [7:0] rd_ptr,
  output reg [7:0] acc_addr_q,
  output reg [7:0] wr_data_q,
  output reg wr_stb_q,
  output reg rd_stb_q,
  output reg stop_q,
  output reg sda_oe_q
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACKA = 3'd2;
  localparam ST_WRX = 3'd3;
  localparam ST_ACKW = 3'd4;
  localparam ST_RDX = 3'd5;
  localparam ST_ACKR = 3'd6;

  reg scl_p_q;
  reg sda_p_q;
  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] ptr_q;
  reg rw_q;
  reg first_q;
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

  assign rd_ptr = ptr_q;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      acc_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      stop_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      stop_q <= 1'b0;
      if (!enable) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start_c) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_c) begin
        stop_q <= 1'b1;
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          ST_ADDR, ST_WRX: begin
            sh_q <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end
          ST_RDX: cnt_q <= cnt_q + 4'h1;
          ST_ACKR: if (sda_s) state_q <= ST_IDLE;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_q)
          ST_ADDR: begin
            if (cnt_q == 4'h8) begin
              if (sh_q[7:1] == `RTCS_SLAVE_ADDR) begin
                rw_q <= sh_q[0];
                sda_oe_q <= 1'b1;
                state_q <= ST_ACKA;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ACKA: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              sh_q <= rd_data;
              sda_oe_q <= ~rd_data[7];
              acc_addr_q <= ptr_q;
              rd_stb_q <= 1'b1;
              ptr_q <= ptr_q + 8'h01;
              state_q <= ST_RDX;
            end else begin
              sda_oe_q <= 1'b0;
              first_q <= 1'b1;
              state_q <= ST_WRX;
            end
          end
          ST_WRX: begin
            if (cnt_q == 4'h8) begin
              sda_oe_q <= 1'b1;
              state_q <= ST_ACKW;
              if (first_q) begin
                ptr_q <= sh_q;
              end else begin
                acc_addr_q <= ptr_q;
                wr_data_q <= sh_q;
                wr_stb_q <= 1'b1;
              end
            end
          end
          ST_ACKW: begin
            if (!first_q)
              ptr_q <= ptr_q + 8'h01;
            first_q <= 1'b0;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
            state_q <= ST_WRX;
          end
          ST_RDX: begin
            if (cnt_q == 4'h8) begin
              sda_oe_q <= 1'b0;
              state_q <= ST_ACKR;
            end else begin
              sda_oe_q <= ~sh_q[3'd7 - cnt_q[2:0]];
            end
          end
          ST_ACKR: state_q <= ST_ACKA;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // rtcs_i2c_slave

// ---- logic/rtcs_timebase.v ----
// 32.768 kHz timebase: crystal divider or external pin, prescaler
// assumes ext_lvl is already synchronised to clock
`timescale 1ns/10ps
`include "rtcs_consts.vh"

module rtcs_timebase #(
  parameter HALF_CYC = `RTCS_TB_HALF_CYC
) (
  input wire clock,
  input wire rst_b,
  input wire osc_disable,
  input wire ext_lvl,
  input wire resync,
  output wire tb_lvl,
  output reg tick_q,
  output reg [19:0] cnt_q
);
  reg [12:0] div_q;
  reg xtal_q;
  reg prev_q;

  // crystal stopped while the external source is in use
  assign tb_lvl = osc_disable ? ext_lvl : xtal_q;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 13'h0000;
      xtal_q <= 1'b0;
      prev_q <= 1'b0;
      tick_q <= 1'b0;
      cnt_q <= 20'h00000;
    end else begin
      if (osc_disable) begin
        div_q <= 13'h0000;
      end else if (div_q == HALF_CYC[12:0] - 13'h0001) begin
        div_q <= 13'h0000;
        xtal_q <= ~xtal_q;
      end else begin
        div_q <= div_q + 13'h0001;
      end
      prev_q <= tb_lvl;
      tick_q <= tb_lvl & ~prev_q;
      if (resync)
        cnt_q <= 20'h00000;
      else if (tick_q)
        cnt_q <= cnt_q + 20'h00001;
    end
  end
endmodule // rtcs_timebase

// ---- logic/rtcs_top.v ----
// rtc control and status registers behind a two-wire serial slave
// assumes supply comparators, tamper, scl/sda arrive asynchronously
// Operation
// - power-loss flag reads 1 after power-up from total supply loss
// - losing only one supply leaves the power-loss flag untouched
// - first enabled time-keeping byte write clears the power-loss flag
// - switching to backup supply sets battery flag until cleared
// - writing 0 clears battery, alarm, event flags; writing 1 does nothing
// - enabled alarm match sets the alarm flag
// - alarm set during a status read survives that read's auto-clear
// - enabled tamper high sets event flag, drives event pin low, stamps time
// - timestamp kept while event flag set; next stamp after clearing
// - auto-clear clears battery, alarm, event after status read with stop
// - time writes accepted only with clock-write enable, reset 0
// - after time write and stop, clock counts, 1Hz resynced to stop
// - oscillator-disable selects external pin timebase, reset 0
// - output select code picks clock output frequency, 0 is off
// - battery-off bit disables clock output while on backup
// - switch mode 0 needs both comparators, mode 1 only hysteresis one
// - alarm enable gates alarm; nonzero output select disables alarm
// - pulse mode: each match gives one 250ms low interrupt pulse
// - level mode: interrupt low until alarm flag cleared
// - time-keeping section occupies addresses 00h to 06h
`timescale 1ns/10ps
`include "rtcs_consts.vh"

module rtcs_top #(
  parameter PULSE_CYC = `RTCS_PULSE_CYC
) (
  input wire clock,
  input wire rst_b,
  input wire scl_pin,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire oscillator_input_pin,
  input wire tamper_input_pin,
  input wire event_detect_enable,
  input wire main_below_backup_hys,
  input wire main_below_trip,
  input wire alarm_match,
  output wire clock_output_pin_out,
  output reg clock_output_pin_oe,
  output wire event_output_n_out,
  output reg event_output_n_oe,
  output wire irq_n_out,
  output reg irq_n_oe,
  output reg on_battery_q,
  output reg crystal_enable_q,
  output reg tick_1hz_q
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  wire [5:0] async_in = {main_below_trip, main_below_backup_hys, tamper_input_pin,
                         oscillator_input_pin, sda_in, scl_pin};
  wire scl_s = sync2_q[0];
  wire sda_s = sync2_q[1];
  wire osc_s = sync2_q[2];
  wire tamper_s = sync2_q[3];
  wire below_hys_s = sync2_q[4];
  wire below_trip_s = sync2_q[5];

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 6'h03;
      sync2_q <= 6'h03;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  reg [7:0] time_q [0:`RTCS_TIME_BYTES-1];
  reg [7:0] ts_q [0:`RTCS_TS_BYTES-1];
  reg power_loss_flag_q;
  reg battery_switch_flag_q;
  reg alarm_match_flag_q;
  reg tamper_event_flag_q;
  reg clock_write_enable_q;
  reg oscillator_disable_q;
  reg status_autoclear_enable_q;
  reg [7:0] intctl_q;
  reg running_q;
  reg time_wr_pend_q;
  reg sr_rd_pend_q;
  reg alm_during_rd_q;
  reg [25:0] pulse_cnt_q;

  wire [3:0] clkout_select = intctl_q[`RTCS_INT_SEL_MSB:`RTCS_INT_SEL_LSB];
  wire clkout_battery_off = intctl_q[`RTCS_INT_FOBAT];
  wire supply_switch_mode = intctl_q[`RTCS_INT_SWMODE];
  wire alarm_function_enable = intctl_q[`RTCS_INT_ALARM_FUNCTION_ENABLE];
  wire alarm_pulse_mode = intctl_q[`RTCS_INT_PULSE];

  // ---------------------------------------------------------------
  // serial slave and timebase
  // ---------------------------------------------------------------
  wire [7:0] rd_ptr;
  wire [7:0] acc_addr;
  wire [7:0] wr_data;
  wire wr_stb;
  wire rd_stb;
  wire stop_stb;
  wire slave_oe;
  reg [7:0] rd_data;

  rtcs_i2c_slave u_slave (
    .clock(clock),
    .rst_b(rst_b),
    .enable(~(on_battery_q & supply_switch_mode)),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .rd_data(rd_data),
    .rd_ptr(rd_ptr),
    .acc_addr_q(acc_addr),
    .wr_data_q(wr_data),
    .wr_stb_q(wr_stb),
    .rd_stb_q(rd_stb),
    .stop_q(stop_stb),
    .sda_oe_q(slave_oe)
  );
  assign sda_out = 1'b0;
  assign sda_oe = slave_oe;

  wire resync = stop_stb & time_wr_pend_q;
  wire tb_lvl;
  wire tb_tick;
  wire [19:0] tb_cnt;

  rtcs_timebase u_tb (
    .clock(clock),
    .rst_b(rst_b),
    .osc_disable(oscillator_disable_q),
    .ext_lvl(osc_s),
    .resync(resync),
    .tb_lvl(tb_lvl),
    .tick_q(tb_tick),
    .cnt_q(tb_cnt)
  );
  wire sec_tick = tb_tick & (tb_cnt[14:0] == `RTCS_SEC_MASK);

  // ---------------------------------------------------------------
  // decode and events
  // ---------------------------------------------------------------
  wire time_sel = (acc_addr <= `RTCS_ADDR_TIME_LAST);
  wire time_wr = wr_stb & time_sel & clock_write_enable_q;
  wire sr_wr = wr_stb & (acc_addr == `RTCS_ADDR_STATUS);
  wire int_wr = wr_stb & (acc_addr == `RTCS_ADDR_INTCTL);
  wire sr_rd = rd_stb & (acc_addr == `RTCS_ADDR_STATUS);
  wire autoclr = stop_stb & sr_rd_pend_q & status_autoclear_enable_q;
  wire alarm_on = alarm_function_enable & (clkout_select == `RTCS_SEL_OFF);
  wire alm_set = alarm_match & alarm_on;
  wire evt_set = event_detect_enable & tamper_s & ~tamper_event_flag_q;
  wire to_battery = supply_switch_mode ? below_hys_s : (below_hys_s & below_trip_s);

  always @* begin
    rd_data = `RTCS_RST_BYTE;
    if (rd_ptr <= `RTCS_ADDR_TIME_LAST)
      rd_data = time_q[rd_ptr[2:0]];
    else if (rd_ptr == `RTCS_ADDR_STATUS)
      rd_data = {status_autoclear_enable_q, oscillator_disable_q, 1'b0, clock_write_enable_q,
                 tamper_event_flag_q, alarm_match_flag_q, battery_switch_flag_q, power_loss_flag_q};
    else if (rd_ptr == `RTCS_ADDR_INTCTL)
      rd_data = intctl_q;
    else if ((rd_ptr >= `RTCS_ADDR_TS_FIRST) && (rd_ptr <= `RTCS_ADDR_TS_LAST))
      rd_data = ts_q[rd_ptr[2:0] - 3'd4];
  end

  // ---------------------------------------------------------------
  // status and control registers
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_loss_flag_q <= `RTCS_RST_PLOSS;
      battery_switch_flag_q <= 1'b0;
      alarm_match_flag_q <= 1'b0;
      tamper_event_flag_q <= 1'b0;
      clock_write_enable_q <= 1'b0;
      oscillator_disable_q <= 1'b0;
      status_autoclear_enable_q <= 1'b0;
      intctl_q <= `RTCS_RST_BYTE;
      on_battery_q <= 1'b0;
      running_q <= 1'b0;
      time_wr_pend_q <= 1'b0;
      sr_rd_pend_q <= 1'b0;
      alm_during_rd_q <= 1'b0;
    end else begin
      on_battery_q <= to_battery;
      if (time_wr)
        power_loss_flag_q <= 1'b0;
      if (sr_wr) begin
        clock_write_enable_q <= wr_data[`RTCS_SR_WREN];
        oscillator_disable_q <= wr_data[`RTCS_SR_OSCDIS];
        status_autoclear_enable_q <= wr_data[`RTCS_SR_AUTOCLR];
      end
      if (int_wr)
        intctl_q <= wr_data;
      // flags: set has priority over any clear
      if (to_battery & ~on_battery_q)
        battery_switch_flag_q <= 1'b1;
      else if (autoclr | (sr_wr & ~wr_data[`RTCS_SR_BAT]))
        battery_switch_flag_q <= 1'b0;
      if (alm_set)
        alarm_match_flag_q <= 1'b1;
      else if ((autoclr & ~alm_during_rd_q) | (sr_wr & ~wr_data[`RTCS_SR_ALM]))
        alarm_match_flag_q <= 1'b0;
      if (evt_set)
        tamper_event_flag_q <= 1'b1;
      else if (autoclr | (sr_wr & ~wr_data[`RTCS_SR_EVT]))
        tamper_event_flag_q <= 1'b0;
      if (stop_stb)
        time_wr_pend_q <= 1'b0;
      else if (time_wr)
        time_wr_pend_q <= 1'b1;
      if (resync)
        running_q <= 1'b1;
      if (stop_stb) begin
        sr_rd_pend_q <= 1'b0;
        alm_during_rd_q <= 1'b0;
      end else begin
        if (sr_rd)
          sr_rd_pend_q <= 1'b1;
        if (alm_set & (sr_rd | sr_rd_pend_q))
          alm_during_rd_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // time-keeping bytes, seconds count, timestamp
  // ---------------------------------------------------------------
  wire [7:0] sec = time_q[0];
  wire [7:0] sec_next = (sec[3:0] != 4'h9) ? {sec[7:4], sec[3:0] + 4'h1} :
                        (sec[6:4] == 3'h5) ? 8'h00 : {1'b0, sec[6:4] + 3'h1, 4'h0};

  genvar gi;
  generate
    for (gi = 0; gi < `RTCS_TIME_BYTES; gi = gi + 1) begin : g_time
      always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          time_q[gi] <= `RTCS_RST_BYTE;
        end else if (time_wr && (acc_addr[2:0] == gi)) begin
          time_q[gi] <= wr_data;
        end else if ((gi == 0) && running_q && sec_tick) begin
          time_q[gi] <= sec_next;
        end
      end
    end
    for (gi = 0; gi < `RTCS_TS_BYTES; gi = gi + 1) begin : g_ts
      always @(posedge clock or negedge rst_b) begin
        if (!rst_b)
          ts_q[gi] <= `RTCS_RST_BYTE;
        else if (evt_set)
          ts_q[gi] <= time_q[gi];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // clock output selection
  // ---------------------------------------------------------------
  reg clock_output_pin_lvl;
  always @* begin
    case (clkout_select)
      4'h1: clock_output_pin_lvl = tb_lvl;
      4'h2: clock_output_pin_lvl = tb_cnt[2];
      4'h3: clock_output_pin_lvl = tb_cnt[4];
      4'h4: clock_output_pin_lvl = tb_cnt[8];
      4'h5: clock_output_pin_lvl = tb_cnt[9];
      4'h6: clock_output_pin_lvl = tb_cnt[10];
      4'h7: clock_output_pin_lvl = tb_cnt[11];
      4'h8: clock_output_pin_lvl = tb_cnt[12];
      4'h9: clock_output_pin_lvl = tb_cnt[13];
      4'hA: clock_output_pin_lvl = tb_cnt[14];
      4'hB: clock_output_pin_lvl = tb_cnt[15];
      4'hC: clock_output_pin_lvl = tb_cnt[16];
      4'hD: clock_output_pin_lvl = tb_cnt[17];
      4'hE: clock_output_pin_lvl = tb_cnt[18];
      4'hF: clock_output_pin_lvl = tb_cnt[19];
      default: clock_output_pin_lvl = 1'b1;
    endcase
  end
  wire clock_output_pin_on = (clkout_select != `RTCS_SEL_OFF) & ~(on_battery_q & clkout_battery_off);

  // ---------------------------------------------------------------
  // interrupt, event and clock output pins
  // ---------------------------------------------------------------
  assign clock_output_pin_out = 1'b0;
  assign event_output_n_out = 1'b0;
  assign irq_n_out = 1'b0;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pulse_cnt_q <= 26'h0000000;
      irq_n_oe <= 1'b0;
      event_output_n_oe <= 1'b0;
      clock_output_pin_oe <= 1'b0;
      crystal_enable_q <= 1'b0;
      tick_1hz_q <= 1'b0;
    end else begin
      if (alm_set & alarm_pulse_mode)
        pulse_cnt_q <= PULSE_CYC[25:0];
      else if (pulse_cnt_q != 26'h0000000)
        pulse_cnt_q <= pulse_cnt_q - 26'h0000001;
      if (alarm_pulse_mode)
        irq_n_oe <= (alm_set | (pulse_cnt_q > 26'h0000001));
      else
        irq_n_oe <= alarm_match_flag_q;
      event_output_n_oe <= tamper_event_flag_q | evt_set;
      clock_output_pin_oe <= clock_output_pin_on & ~clock_output_pin_lvl;
      crystal_enable_q <= ~oscillator_disable_q;
      tick_1hz_q <= sec_tick & running_q;
    end
  end
endmodule // rtcs_top

// ---- verification/rtcs_top_properties.sv ----
// assertions on the rtc control and status top ports
// assumes a bind onto rtcs_top from the bench top file
`timescale 1ns/10ps
module rtcs_top_props (
  input wire clock,
  input wire rst_b,
  input wire sda_out,
  input wire tamper_input_pin,
  input wire event_detect_enable,
  input wire main_below_backup_hys,
  input wire alarm_match,
  input wire clock_output_pin_out,
  input wire event_output_n_out,
  input wire event_output_n_oe,
  input wire irq_n_out,
  input wire irq_n_oe,
  input wire on_battery_q,
  input wire crystal_enable_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // tamper and event output
  // ----------------------------------------
  sequence s_tamper_held;
    (event_detect_enable && tamper_input_pin) [*4];
  endsequence
  sequence s_tamper_quiet;
    (!tamper_input_pin) [*5];
  endsequence
  a_tamper_sets_event: assert property (s_tamper_held |-> ##[0:3] event_output_n_oe)
    else $error("event output missing after tamper");
  a_event_needs_enable: assert property ($rose(event_output_n_oe) |-> $past(event_detect_enable))
    else $error("event output without enable");
  a_quiet_no_event: assert property (s_tamper_quiet |=> !$rose(event_output_n_oe))
    else $error("event output without tamper");
  // ----------------------------------------
  // supply, alarm, pins
  // ----------------------------------------
  a_no_hys_no_batt: assert property ((!main_below_backup_hys) [*6] |-> !on_battery_q)
    else $error("backup supply without comparator");
  a_batt_needs_hys: assert property ($rose(on_battery_q) |-> $past(main_below_backup_hys))
    else $error("backup entered without comparator");
  a_irq_after_match: assert property ($rose(irq_n_oe) |-> $past(alarm_match) || $past(alarm_match, 2))
    else $error("interrupt without alarm match");
  a_crystal_after_rst: assert property ($rose(rst_b) |=> crystal_enable_q)
    else $error("crystal not enabled after reset");
  a_od_pins_low: assert property (!(sda_out || clock_output_pin_out || event_output_n_out || irq_n_out))
    else $error("open drain pin driven high");
endmodule // rtcs_top_props

// ---- verification/rtcs_mst_model.sv ----
// two-wire master model for the rtc serial port
// assumes a pull-up on sda in the bench; scl is push-pull
`timescale 1ns/10ps
`include "rtcs_consts.vh"
module rtcs_mst (
  output logic scl,
  output logic sda_pull,
  input wire sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // data set mid-low, line taken at end of high
  task automatic bit_io(input logic b, output logic r);
    #16 sda_pull = ~b;
    #16 scl = 1'b1;
    #32 r = sda;
    scl = 1'b0;
  endtask
  task automatic start;
    #16 sda_pull = 1'b0;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b1;
    #16 scl = 1'b0;
  endtask
  task automatic stop;
    #16 sda_pull = 1'b1;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b0;
    #16;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    put({`RTCS_SLAVE_ADDR, 1'b0}, k0);
    put(a, k1);
    put(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2, r;
    start();
    put({`RTCS_SLAVE_ADDR, 1'b0}, k0);
    put(a, k1);
    start();
    put({`RTCS_SLAVE_ADDR, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule // rtcs_mst

// ---- verification/tb_top.sv ----
// bench for the rtc control and status registers
// assumes rtcs_top, the master model and the checker compile first
`timescale 1ns/10ps
module tb_top;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  localparam int PC = 100;
  logic clock = 1'b0, rst_b = 1'b0, osc_in = 1'b0, tamper = 1'b0, ev_en = 1'b0;
  logic hys = 1'b0, trip = 1'b0, match = 1'b0, m_scl, m_pull, ok, prev;
  logic [7:0] rv;
  int num_errors = 0, n_compared = 0, n, m;
  wire sda_oe, co_oe, ev_oe, irq_oe, batt, xen;
  wire sda = ~(m_pull | sda_oe);
  wire [3:0] obs = {irq_oe, ev_oe, batt, xen};
  logic [23:0] rows [7] = '{24'h08FFFF, 24'h080000, 24'h07FFD1, 24'h072001, 24'h001200, 24'h09AA00,
    24'h145500};
  rtcs_top #(.PULSE_CYC(PC)) dut_u (.clock(clock), .rst_b(rst_b), .scl_pin(m_scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .oscillator_input_pin(osc_in), .tamper_input_pin(tamper),
    .event_detect_enable(ev_en), .main_below_backup_hys(hys), .main_below_trip(trip),
    .alarm_match(match), .clock_output_pin_out(), .clock_output_pin_oe(co_oe),
    .event_output_n_out(), .event_output_n_oe(ev_oe), .irq_n_out(), .irq_n_oe(irq_oe),
    .on_battery_q(batt), .crystal_enable_q(xen), .tick_1hz_q());
  rtcs_mst mst_u (.scl(m_scl), .sda_pull(m_pull), .sda(sda));
  initial forever #2.5 clock = ~clock;
  initial forever begin
    cyc(20);
    osc_in = ~osc_in;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    mst_u.wr(a, d, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    mst_u.rd(a, rv, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk($sformatf("reg %h", a), e, rv);
  endtask
  task automatic mpulse;
    @(negedge clock);
    match = 1'b1;
    @(negedge clock);
    match = 1'b0;
  endtask
  task automatic tpulse;
    @(negedge clock);
    tamper = 1'b1;
    cyc(10);
    tamper = 1'b0;
    cyc(5);
  endtask
  task automatic wait_sig(input int i, input logic v, input string nm);
    n = 0;
    while (obs[i] !== v) begin
      @(negedge clock);
      n++;
      if (n > 400) begin
        num_errors++;
        $display("Error %s expected %h seen %h", nm, v, obs[i]);
        close_out();
      end
    end
    n_compared++;
  endtask
  task automatic toggles(input logic e, input string nm);
    n = 0;
    cyc(2);
    prev = co_oe;
    repeat (300) begin
      @(negedge clock);
      n += (co_oe !== prev);
      prev = co_oe;
    end
    chk(nm, {7'h00, e}, {7'h00, n > 0});
  endtask
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    cyc(6);
    rst_b = 1'b1;
    cyc(4);
    r(8'h07, 8'h01);
    r(8'h08, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      w(rows[i][23:16], rows[i][15:8]);
      r(rows[i][23:16], rows[i][7:0]);
    end
    $display("table test done");
    w(8'h07, 8'h10);
    r(8'h07, 8'h11);
    w(8'h06, 8'h05);
    r(8'h06, 8'h05);
    r(8'h07, 8'h10);
    w(8'h00, 8'h21);
    w(8'h07, 8'h50);
    wait_sig(0, 1'b0, "crystal enable");
    w(8'h08, 8'h11);
    toggles(1'b1, "clkout on");
    hys = 1'b1;
    cyc(20);
    chk("battery", 8'h00, {7'h00, batt});
    trip = 1'b1;
    wait_sig(1, 1'b1, "battery");
    toggles(1'b0, "clkout batt");
    hys = 1'b0;
    trip = 1'b0;
    wait_sig(1, 1'b0, "battery");
    r(8'h07, 8'h52);
    w(8'h07, 8'h52);
    r(8'h07, 8'h52);
    w(8'h07, 8'h10);
    r(8'h07, 8'h10);
    w(8'h08, 8'h00);
    toggles(1'b0, "clkout off");
    w(8'h07, 8'h90);
    w(8'h08, 8'h20);
    cyc(1);
    hys = 1'b1;
    wait_sig(1, 1'b1, "battery");
    hys = 1'b0;
    wait_sig(1, 1'b0, "battery");
    r(8'h07, 8'h92);
    r(8'h07, 8'h90);
    w(8'h08, 8'h00);
    $display("supply test done");
    w(8'h08, 8'h40);
    mpulse();
    wait_sig(3, 1'b1, "irq level");
    cyc(50);
    chk("irq held", 8'h01, {7'h00, irq_oe});
    r(8'h07, 8'h94);
    wait_sig(3, 1'b0, "irq release");
    fork
      r(8'h07, 8'h90);
      begin
        cyc(460);
        mpulse();
      end
    join
    r(8'h07, 8'h94);
    r(8'h07, 8'h90);
    for (int i = 0; i < 2; i++) begin
      w(8'h08, i ? 8'h00 : 8'h41);
      mpulse();
      cyc(10);
      chk("irq masked", 8'h00, {7'h00, irq_oe});
      r(8'h07, 8'h90);
    end
    w(8'h08, 8'hC0);
    for (int k = 0; k < 2; k++) begin
      mpulse();
      wait_sig(3, 1'b1, "irq pulse");
      m = 0;
      while (irq_oe === 1'b1 && m < 300) begin
        @(negedge clock);
        m++;
      end
      chk("pulse len", 8'h01, {7'h00, m >= PC - 2 && m <= PC + 2});
      if (m >= 300) close_out();
      cyc(20);
    end
    r(8'h07, 8'h94);
    w(8'h08, 8'h00);
    $display("alarm test done");
    tpulse();
    chk("event disabled", 8'h00, {7'h00, ev_oe});
    ev_en = 1'b1;
    tpulse();
    chk("event pin", 8'h01, {7'h00, ev_oe});
    r(8'h14, 8'h21);
    w(8'h00, 8'h33);
    tpulse();
    r(8'h14, 8'h21);
    r(8'h07, 8'h98);
    wait_sig(2, 1'b0, "event release");
    tpulse();
    r(8'h14, 8'h33);
    $display("tamper test done");
    close_out();
  end
endmodule // tb_top
bind rtcs_top rtcs_top_props chk_u (.clock(clock), .rst_b(rst_b), .sda_out(sda_out),
  .tamper_input_pin(tamper_input_pin), .event_detect_enable(event_detect_enable),
  .main_below_backup_hys(main_below_backup_hys), .alarm_match(alarm_match),
  .clock_output_pin_out(clock_output_pin_out), .event_output_n_out(event_output_n_out),
  .event_output_n_oe(event_output_n_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
  .on_battery_q(on_battery_q), .crystal_enable_q(crystal_enable_q));
